// file: cps_pkg.sv
// Constants, types and register layout for the codec power sequencer
package cps_pkg;

	localparam int CLK_MHZ           = 200;
	localparam int CP_POWERUP_NS     = 1300000;
	localparam int CP_POWERUP_CYC    = (CP_POWERUP_NS * CLK_MHZ + 999) / 1000;
	localparam int CLK_LOSS_NS       = 100000;
	localparam int CLK_LOSS_CYC      = (CLK_LOSS_NS * CLK_MHZ) / 1000;
	localparam int REF_SETTLE_FRAMES = 2048;
	localparam int ADC_INIT_FRAMES   = 2640;
	localparam int DAC_INIT_FRAMES   = 6 * 8 * 2;
	localparam int MASTER_PER_FRAME  = 256;

	localparam logic [2:0] ADDR_POWER     = 3'h0;
	localparam logic [2:0] ADDR_ADC_INPUT = 3'h1;
	localparam logic [2:0] ADDR_ADC_CLOCK = 3'h2;
	localparam logic [2:0] ADDR_DAC_CLOCK = 3'h3;
	localparam logic [2:0] ADDR_STATUS    = 3'h4;

	localparam logic [7:0] MASK_POWER     = 8'h03;
	localparam logic [7:0] MASK_ADC_INPUT = 8'h03;
	localparam logic [7:0] MASK_ADC_CLOCK = 8'h16;
	localparam logic [7:0] MASK_DAC_CLOCK = 8'h7F;
	localparam logic [7:0] RST_POWER      = 8'h00;
	localparam logic [7:0] RST_ADC_INPUT  = 8'h00;
	localparam logic [7:0] RST_ADC_CLOCK  = 8'h00;
	localparam logic [7:0] RST_DAC_CLOCK  = 8'h04;

	localparam int BIT_ADC_POWER = 0;
	localparam int BIT_DAC_POWER = 1;
	localparam int BIT_MUTE      = 0;
	localparam int SPEED_LSB     = 4;

	localparam logic [1:0] SPEED_NORMAL = 2'h0;
	localparam logic [1:0] SPEED_QUAD   = 2'h2;

	localparam int          GAIN_W      = 13;
	localparam logic [12:0] GAIN_UNITY  = 13'h1000;
	localparam logic [12:0] STEP_NORMAL = 13'h0004;

	typedef struct packed {
		logic adcMasterClk;
		logic adcFrameClk;
		logic adcBitClk;
		logic dacMasterClk;
		logic dacFrameClk;
		logic dacBitClk;
	} cps_clkpins_s;

	typedef enum logic [1:0] {ADC_OFF, ADC_WAIT, ADC_INIT, ADC_RUN} cps_adc_state_e;
	typedef enum logic [1:0] {DAC_OFF, DAC_WAIT, DAC_INIT, DAC_RUN} cps_dac_state_e;

endpackage

// file: cps_power_seq.sv
// Power-down, start-up sequencing, charge pump control and DAC soft mute
// Function
// [R01] Mute set: ramp to full mute, 1024 frames
// [R02] Mute cleared: ramp back to unity, 1024 frames
// [R03] Early unmute returns over cycles spent
// [R04] Ramp 2048 double speed, 4096 quad speed
// [R05] Pump on: ADC pin, bit, clocks active
// [R06] Pump on: DAC pin, bit, clocks active
// [R07] Pin control mode ignores register settings
// [R08] Converters start only after pump ready
// [R09] ADC pin low resets ADC logic, registers
// [R10] DAC pin low resets DAC logic, register
// [R11] Both pins low: everything reset, off
// [R12] After pin release blocks stay off
// [R13] Powered down: ADC data low, DAC 0V
// [R14] ADC master mode starts on master clock
// [R15] ADC slave mode starts on frame edge
// [R16] DAC starts on frame rising edge
// [R17] ADC data valid after 2640 frames
// [R18] DAC held at 0V during init interval
// [R19] Power bit clear: half off, registers kept
// [R20] Host holds pins low 150 ns at power-up
// [R21] Reference settles 2048 frames after pump
// [R22] Pump off only when both halves disabled
// [R23] Gain moves one equal step per frame
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module cps_power_seq #(
	parameter int CP_POWERUP_CYC = cps_pkg::CP_POWERUP_CYC,
	parameter int CLK_LOSS_CYC   = cps_pkg::CLK_LOSS_CYC
) (
	input  wire logic                 clock,
	input  wire logic                 srst,
	input  wire logic [2:0]           addr,
	input  wire logic [7:0]           wrData,
	input  wire logic                 wrStb,
	input  wire logic                 rdStb,
	output logic      [7:0]           rdData,
	input  wire logic                 adcPowerdownN,
	input  wire logic                 dacPowerdownN,
	input  wire logic                 adcMasterMode,
	input  wire logic                 pinControlMode,
	input  wire cps_pkg::cps_clkpins_s clkPins,
	output logic                      chargePumpOn,
	output logic                      refSettled,
	output logic                      adcRunning,
	output logic                      adcDataValid,
	output logic                      dacRunning,
	output logic                      dacOutputEnable,
	output logic      [12:0]          dacGain
);

	localparam int CP_W   = $clog2(CP_POWERUP_CYC + 1);
	localparam int LOSS_W = $clog2(CLK_LOSS_CYC + 1);

	if (CP_POWERUP_CYC < 1 || CLK_LOSS_CYC < 2) begin : badParams
		$error("cps_power_seq: counts must be positive");
	end

	// Saturating gain step per frame: 4 normal, 2 double, 1 quad
	function automatic logic [12:0] rampStep(input logic [1:0] speed);
		return cps_pkg::STEP_NORMAL >> speed;
	endfunction

	// Pin synchronisers; third stage only feeds edge detection
	logic [9:0] sync1_ff;
	logic [9:0] sync2_ff;
	logic [9:0] sync3_ff;
	logic [9:0] pinsRaw;
	assign pinsRaw = {adcPowerdownN, dacPowerdownN, adcMasterMode, pinControlMode, clkPins};

	always_ff @(posedge clock) begin
		if (srst) begin
			sync1_ff <= 10'h000;
			sync2_ff <= 10'h000;
			sync3_ff <= 10'h000;
		end else begin
			sync1_ff <= pinsRaw;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	logic adcPdn;
	logic dacPdn;
	logic masterMode;
	logic hwMode;
	logic [5:0] clkRise;
	logic [5:0] clkToggle;
	assign adcPdn     = sync2_ff[9];
	assign dacPdn     = sync2_ff[8];
	assign masterMode = sync2_ff[7];
	assign hwMode     = sync2_ff[6];
	assign clkRise    = sync2_ff[5:0] & ~sync3_ff[5:0];
	assign clkToggle  = sync2_ff[5:0] ^ sync3_ff[5:0];

	// Clock presence: a clock that has not toggled for the loss window is absent
	logic [LOSS_W-1:0] lossCnt_ff [6];
	logic [5:0]        clkActive;

	always_ff @(posedge clock) begin
		for (int i = 0; i < 6; i++) begin
			if (srst || clkToggle[i]) begin
				lossCnt_ff[i] <= '0;
			end else if (lossCnt_ff[i] != LOSS_W'(CLK_LOSS_CYC)) begin
				lossCnt_ff[i] <= lossCnt_ff[i] + 1'b1;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 6; i++) begin
			clkActive[i] = lossCnt_ff[i] != LOSS_W'(CLK_LOSS_CYC);
		end
	end

	// Bit order of clkPins: 5 adc master, 4 adc frame, 3 adc bit, 2 dac master, 1 dac frame
	logic adcClocksOk;
	logic dacClocksOk;
	assign adcClocksOk = masterMode ? clkActive[5] : &clkActive[5:3]; // see [R05]
	assign dacClocksOk = &clkActive[2:0]; // see [R06]

	// Register file
	logic [7:0] powerReg_ff;
	logic [7:0] adcInputReg_ff;
	logic [7:0] adcClockReg_ff;
	logic [7:0] dacClockReg_ff;
	logic       wrPower;
	logic       wrAdcInput;
	logic       wrAdcClock;
	logic       wrDacClock;
	assign wrPower    = wrStb && addr == cps_pkg::ADDR_POWER;
	assign wrAdcInput = wrStb && addr == cps_pkg::ADDR_ADC_INPUT;
	assign wrAdcClock = wrStb && addr == cps_pkg::ADDR_ADC_CLOCK;
	assign wrDacClock = wrStb && addr == cps_pkg::ADDR_DAC_CLOCK;

	always_ff @(posedge clock) begin
		if (srst || !adcPdn) begin // see [R09] [R11]
			adcInputReg_ff <= cps_pkg::RST_ADC_INPUT;
			adcClockReg_ff <= cps_pkg::RST_ADC_CLOCK;
		end else begin
			if (wrAdcInput) begin
				adcInputReg_ff <= wrData & cps_pkg::MASK_ADC_INPUT;
			end
			if (wrAdcClock) begin
				adcClockReg_ff <= wrData & cps_pkg::MASK_ADC_CLOCK;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst || !dacPdn) begin // see [R10]
			dacClockReg_ff <= cps_pkg::RST_DAC_CLOCK;
		end else if (wrDacClock) begin
			dacClockReg_ff <= wrData & cps_pkg::MASK_DAC_CLOCK;
		end
	end

	// Each power bit is cleared by its own pin, so one half can reset alone
	always_ff @(posedge clock) begin
		if (srst) begin
			powerReg_ff <= cps_pkg::RST_POWER;
		end else begin
			if (wrPower) begin
				powerReg_ff <= wrData & cps_pkg::MASK_POWER;
			end
			if (!adcPdn) begin // see [R09]
				powerReg_ff[cps_pkg::BIT_ADC_POWER] <= 1'b0;
			end
			if (!dacPdn) begin // see [R10]
				powerReg_ff[cps_pkg::BIT_DAC_POWER] <= 1'b0;
			end
		end
	end

	// Pin control mode forces power on and register defaults for mute and speed
	logic       adcPowerBit;
	logic       dacPowerBit;
	logic       muteCtl;
	logic [1:0] speed;
	assign adcPowerBit = hwMode || powerReg_ff[cps_pkg::BIT_ADC_POWER]; // see [R07]
	assign dacPowerBit = hwMode || powerReg_ff[cps_pkg::BIT_DAC_POWER]; // see [R07]
	assign muteCtl     = !hwMode && dacClockReg_ff[cps_pkg::BIT_MUTE];
	assign speed       = hwMode ? cps_pkg::SPEED_NORMAL
	                   : (dacClockReg_ff[cps_pkg::SPEED_LSB +: 2] > cps_pkg::SPEED_QUAD
	                      ? cps_pkg::SPEED_QUAD : dacClockReg_ff[cps_pkg::SPEED_LSB +: 2]);

	logic adcEnable;
	logic dacEnable;
	logic cpRequest;
	assign adcEnable = adcPdn && adcPowerBit && adcClocksOk; // see [R05] [R19]
	assign dacEnable = dacPdn && dacPowerBit && dacClocksOk; // see [R06] [R19]
	assign cpRequest = adcEnable || dacEnable; // see [R22]

	// Charge pump power-up timer
	logic [CP_W-1:0] cpCnt_ff;
	logic            cpOn_ff;
	logic            cpReady_ff;

	always_ff @(posedge clock) begin
		if (srst || !cpRequest) begin // see [R22] [R11]
			cpOn_ff    <= 1'b0;
			cpReady_ff <= 1'b0;
			cpCnt_ff   <= '0;
		end else begin
			cpOn_ff <= 1'b1;
			if (cpCnt_ff == CP_W'(CP_POWERUP_CYC - 1)) begin
				cpReady_ff <= 1'b1;
			end else begin
				cpCnt_ff <= cpCnt_ff + 1'b1;
			end
		end
	end

	// Master mode: the ADC frame rate is derived from its master clock
	logic [7:0] masterDiv_ff;
	logic       adcFrameTick;
	assign adcFrameTick = masterMode
	                    ? (clkRise[5] && masterDiv_ff == 8'(cps_pkg::MASTER_PER_FRAME - 1))
	                    : clkRise[4];

	always_ff @(posedge clock) begin
		if (srst || !adcPdn) begin
			masterDiv_ff <= 8'h00;
		end else if (clkRise[5]) begin
			masterDiv_ff <= masterDiv_ff + 8'h01;
		end
	end

	// Reference settling, counted on whichever half supplies frames
	logic [11:0] refCnt_ff;
	logic        refSettled_ff;

	always_ff @(posedge clock) begin
		if (srst || !cpReady_ff) begin
			refCnt_ff     <= 12'h000;
			refSettled_ff <= 1'b0;
		end else if ((adcFrameTick || clkRise[1]) && !refSettled_ff) begin // see [R21]
			refCnt_ff     <= refCnt_ff + 12'h001;
			refSettled_ff <= refCnt_ff == 12'(cps_pkg::REF_SETTLE_FRAMES - 1);
		end
	end

	// ADC sequence
	cps_pkg::cps_adc_state_e adcState_ff;
	logic [11:0]             adcInitCnt_ff;
	logic                    adcValid_ff;
	logic                    adcStart;
	assign adcStart = masterMode ? clkRise[5] : clkRise[4]; // see [R14] [R15]

	always_ff @(posedge clock) begin
		if (srst || !adcEnable) begin // see [R12] [R19]
			adcState_ff   <= cps_pkg::ADC_OFF;
			adcInitCnt_ff <= 12'h000;
			adcValid_ff   <= 1'b0;
		end else begin
			case (adcState_ff)
				cps_pkg::ADC_OFF: begin
					if (cpReady_ff) begin // see [R08]
						adcState_ff <= cps_pkg::ADC_WAIT;
					end
				end
				cps_pkg::ADC_WAIT: begin
					if (adcStart) begin
						adcState_ff   <= cps_pkg::ADC_INIT;
						adcInitCnt_ff <= 12'h000;
					end
				end
				cps_pkg::ADC_INIT: begin
					if (adcFrameTick) begin // see [R17]
						adcInitCnt_ff <= adcInitCnt_ff + 12'h001;
						if (adcInitCnt_ff == 12'(cps_pkg::ADC_INIT_FRAMES - 1)) begin
							adcState_ff <= cps_pkg::ADC_RUN;
							adcValid_ff <= 1'b1;
						end
					end
				end
				cps_pkg::ADC_RUN: begin
					adcValid_ff <= 1'b1;
				end
				default: begin
					adcState_ff <= cps_pkg::ADC_OFF;
				end
			endcase
		end
	end

	// DAC sequence; init length scales with speed
	cps_pkg::cps_dac_state_e dacState_ff;
	logic [8:0]              dacInitCnt_ff;
	logic                    dacOut_ff;
	logic [8:0]              dacInitLast;
	assign dacInitLast = 9'((cps_pkg::DAC_INIT_FRAMES << speed) - 1);

	always_ff @(posedge clock) begin
		if (srst || !dacEnable) begin // see [R12] [R19]
			dacState_ff   <= cps_pkg::DAC_OFF;
			dacInitCnt_ff <= 9'h000;
			dacOut_ff     <= 1'b0;
		end else begin
			case (dacState_ff)
				cps_pkg::DAC_OFF: begin
					if (cpReady_ff) begin // see [R08]
						dacState_ff <= cps_pkg::DAC_WAIT;
					end
				end
				cps_pkg::DAC_WAIT: begin
					if (clkRise[1]) begin // see [R16]
						dacState_ff   <= cps_pkg::DAC_INIT;
						dacInitCnt_ff <= 9'h000;
					end
				end
				cps_pkg::DAC_INIT: begin
					if (clkRise[1]) begin // see [R18]
						dacInitCnt_ff <= dacInitCnt_ff + 9'h001;
						if (dacInitCnt_ff >= dacInitLast) begin
							dacState_ff <= cps_pkg::DAC_RUN;
							dacOut_ff   <= 1'b1;
						end
					end
				end
				cps_pkg::DAC_RUN: begin
					dacOut_ff <= 1'b1;
				end
				default: begin
					dacState_ff <= cps_pkg::DAC_OFF;
				end
			endcase
		end
	end

	// Soft mute ramp: the gain itself is the ramp position, so an early
	// unmute simply walks back from wherever the down-ramp stopped
	logic [12:0] gain_ff;
	logic [12:0] step;
	assign step = rampStep(speed);

	always_ff @(posedge clock) begin
		if (srst || !dacPdn) begin
			gain_ff <= cps_pkg::GAIN_UNITY;
		end else if (clkRise[1]) begin // see [R23] [R04]
			if (muteCtl) begin // see [R01]
				gain_ff <= (gain_ff > step) ? gain_ff - step : 13'h0000;
			end else if (gain_ff != cps_pkg::GAIN_UNITY) begin // see [R02] [R03]
				gain_ff <= (cps_pkg::GAIN_UNITY - gain_ff > step)
				         ? gain_ff + step : cps_pkg::GAIN_UNITY;
			end
		end
	end

	// Read port; data stand only in the cycle after the strobe
	logic [7:0] rdData_ff;
	logic [7:0] statusWord;
	logic [7:0] rdMux;
	assign statusWord = {gain_ff == 13'h0000, dacOut_ff, dacState_ff == cps_pkg::DAC_RUN
	                     || dacState_ff == cps_pkg::DAC_INIT, adcValid_ff,
	                     adcState_ff == cps_pkg::ADC_RUN || adcState_ff == cps_pkg::ADC_INIT,
	                     refSettled_ff, cpReady_ff, cpOn_ff};

	always_comb begin
		case (addr)
			cps_pkg::ADDR_POWER:     rdMux = powerReg_ff;
			cps_pkg::ADDR_ADC_INPUT: rdMux = adcInputReg_ff;
			cps_pkg::ADDR_ADC_CLOCK: rdMux = adcClockReg_ff;
			cps_pkg::ADDR_DAC_CLOCK: rdMux = dacClockReg_ff;
			cps_pkg::ADDR_STATUS:    rdMux = statusWord;
			default:                 rdMux = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rdData_ff <= 8'h00;
		end else begin
			rdData_ff <= rdStb ? rdMux : 8'h00;
		end
	end

	// Converter outputs only go live when their own flags are up
	logic adcRun_ff;
	logic dacRun_ff;
	logic [12:0] gainOut_ff;

	always_ff @(posedge clock) begin
		if (srst) begin
			adcRun_ff  <= 1'b0;
			dacRun_ff  <= 1'b0;
			gainOut_ff <= cps_pkg::GAIN_UNITY;
		end else begin
			adcRun_ff  <= adcState_ff == cps_pkg::ADC_INIT || adcState_ff == cps_pkg::ADC_RUN;
			dacRun_ff  <= dacState_ff == cps_pkg::DAC_INIT || dacState_ff == cps_pkg::DAC_RUN;
			gainOut_ff <= gain_ff;
		end
	end

	assign rdData          = rdData_ff;
	assign chargePumpOn    = cpOn_ff;
	assign refSettled      = refSettled_ff;
	assign adcRunning      = adcRun_ff;
	assign adcDataValid    = adcValid_ff; // see [R13]
	assign dacRunning      = dacRun_ff;
	assign dacOutputEnable = dacOut_ff; // see [R13] [R18]
	assign dacGain         = gainOut_ff;

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	sequence dacFrameStart_q;
		dacEnable && dacState_ff == cps_pkg::DAC_WAIT && clkRise[1];
	endsequence

	cp_off_a: assert property (!cpRequest |=> !cpOn_ff && !cpReady_ff) // see [R22]
		else $error("charge pump stayed on with both halves disabled");
	cp_on_a: assert property (cpRequest && !cpOn_ff |=> cpOn_ff) // see [R05]
		else $error("charge pump did not start");
	cp_ready_a: assert property (adcState_ff == cps_pkg::ADC_INIT |-> cpReady_ff) // see [R08]
		else $error("ADC initialised before charge pump ready");
	adc_reset_a: assert property (!adcPdn |=> adcInputReg_ff == cps_pkg::RST_ADC_INPUT
		&& !powerReg_ff[cps_pkg::BIT_ADC_POWER] && !adcValid_ff) // see [R09]
		else $error("ADC pin low did not reset ADC state");
	dac_reset_a: assert property (!dacPdn |=> dacClockReg_ff == cps_pkg::RST_DAC_CLOCK
		&& gain_ff == cps_pkg::GAIN_UNITY && !dacOut_ff) // see [R10]
		else $error("DAC pin low did not reset DAC state");
	adc_valid_a: assert property ($rose(adcValid_ff) |-> // see [R17]
		$past(adcInitCnt_ff) == 12'(cps_pkg::ADC_INIT_FRAMES - 1))
		else $error("ADC data valid before init count");
	dac_start_a: assert property (dacFrameStart_q |=> // see [R16]
		dacState_ff == cps_pkg::DAC_INIT && !dacOut_ff)
		else $error("DAC did not start on frame edge");
	dac_zero_a: assert property (dacOut_ff |-> dacState_ff == cps_pkg::DAC_RUN) // see [R18]
		else $error("DAC output enabled outside run");
	mute_down_a: assert property (dacPdn && clkRise[1] && muteCtl && gain_ff > step // see [R01]
		|=> gain_ff == $past(gain_ff) - $past(step))
		else $error("mute ramp step wrong");
	mute_up_a: assert property (dacPdn && clkRise[1] && !muteCtl // see [R02]
		&& cps_pkg::GAIN_UNITY - gain_ff > step |=> gain_ff == $past(gain_ff) + $past(step))
		else $error("unmute ramp step wrong");
	keep_regs_a: assert property (adcPdn && !wrAdcInput ##1 adcPdn // see [R19]
		|-> $stable(adcInputReg_ff))
		else $error("ADC register changed without write");

endmodule

`default_nettype wire

// file: cps_host_model.sv
// Host-side model: supplies the port clocks of both converter halves
`timescale 1ns/1ps
`default_nettype none

module cps_host_model (
	input  wire logic                 clock,
	input  wire logic                 adcClkOn,
	input  wire logic                 dacClkOn,
	input  wire logic                 adcMasterOnly,
	output var cps_pkg::cps_clkpins_s clkPins
);
	logic [2:0] phase = 3'h0;
	logic       frameHi;

	always_ff @(posedge clock) begin
		phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
	end

	// Each level holds three cycles so the device synchronisers never miss an edge
	assign frameHi = (phase < 3'h3);

	// A stopped clock parks low; it never freezes at its last level
	always_comb begin
		clkPins.adcMasterClk = adcClkOn & frameHi;
		// In master mode only the master clock comes from the host
		clkPins.adcFrameClk  = adcClkOn & ~adcMasterOnly & frameHi;
		clkPins.adcBitClk    = adcClkOn & ~adcMasterOnly & ~frameHi;
		clkPins.dacMasterClk = dacClkOn & frameHi;
		clkPins.dacFrameClk  = dacClkOn & frameHi;
		clkPins.dacBitClk    = dacClkOn & ~frameHi;
	end
endmodule

`default_nettype wire

// file: tb_cps_power_seq.sv
// Self-checking bench for the codec power sequencer and soft mute
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end

module tb_cps_power_seq;
	localparam int CP   = 50;
	localparam int LOSS = 40;
	localparam int LIMIT = 90000;
	logic                  clock      = 1'b0;
	logic                  srst       = 1'b1;
	logic [2:0]            addr       = 3'h0;
	logic [7:0]            wrData     = 8'h00;
	logic                  wrStb      = 1'b0;
	logic                  rdStb      = 1'b0;
	logic                  adcPdN     = 1'b0;
	logic                  dacPdN     = 1'b0;
	logic                  masterMode = 1'b0;
	logic                  pinMode    = 1'b0;
	logic                  adcOn      = 1'b0;
	logic                  dacOn      = 1'b0;
	logic                  adcMstOnly = 1'b0;
	logic [7:0]            rdData;
	cps_pkg::cps_clkpins_s clkPins;
	logic                  pumpOn, refOk, adcRun, adcValid, dacRun, dacOe;
	logic [12:0]           dacGain;
	logic                  adcFrQ, dacFrQ, adcRunQ, adcValQ;
	int                    error_cnt   = 0;
	int                    check_count = 0;
	int                    cycles      = 0;
	int                    adcFr       = 0;
	int                    dacFr       = 0;
	int                    adcStart    = 0;
	int                    adcDone     = 0;
	int                    n, k, r, f, sp;

	cps_power_seq #(.CP_POWERUP_CYC(CP), .CLK_LOSS_CYC(LOSS)) dut (
		.clock(clock), .srst(srst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .adcPowerdownN(adcPdN), .dacPowerdownN(dacPdN),
		.adcMasterMode(masterMode), .pinControlMode(pinMode), .clkPins(clkPins),
		.chargePumpOn(pumpOn), .refSettled(refOk), .adcRunning(adcRun),
		.adcDataValid(adcValid), .dacRunning(dacRun), .dacOutputEnable(dacOe),
		.dacGain(dacGain)
	);

	cps_host_model host (
		.clock(clock), .adcClkOn(adcOn), .dacClkOn(dacOn), .adcMasterOnly(adcMstOnly),
		.clkPins(clkPins)
	);

	initial begin
		forever #2.5 clock = ~clock;
	end

	// Frame counting and a hang guard
	always @(posedge clock) begin
		adcFrQ <= clkPins.adcFrameClk;
		dacFrQ <= clkPins.dacFrameClk;
		adcRunQ <= adcRun;
		adcValQ <= adcValid;
		if (clkPins.adcFrameClk && !adcFrQ) adcFr <= adcFr + 1;
		if (clkPins.dacFrameClk && !dacFrQ) dacFr <= dacFr + 1;
		if (adcRun === 1'b1 && adcRunQ !== 1'b1 && adcStart == 0) adcStart <= adcFr;
		if (adcValid === 1'b1 && adcValQ !== 1'b1 && adcDone == 0) adcDone <= adcFr;
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			error_cnt++;
			results();
		end
	end

	function automatic int near(input int v, input int e, input int tol);
		return ((v - e) <= tol && (e - v) <= tol) ? e : v;
	endfunction

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clock);
		wrStb <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
		@(posedge clock);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clock);
		rdStb <= 1'b0;
		#1;
		`CHK(nm, e, rdData)
	endtask

	// Frames from now until the gain lands on the target
	task automatic ramp(input logic [12:0] target, output int frames);
		int s;
		s = dacFr;
		for (n = 0; n < 40000 && dacGain !== target; n++) @(posedge clock);
		frames = dacFr - s;
	endtask

	task automatic hold(input int c);
		repeat (c) @(posedge clock);
		#1;
	endtask

	task automatic results();
		$display("checks=%0d mismatches=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		r = $urandom(43456);
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		hold(1);
		`CHK("gainRst", 13'h1000, dacGain)
		`CHK("flagsRst", 6'h00, {pumpOn, refOk, adcRun, adcValid, dacRun, dacOe})
		rd(3'h3, 8'h04, "dacRegRst");
		wr(3'h0, 8'h03);
		rd(3'h0, 8'h00, "pwrPinLow");
		hold(30);
		@(posedge clock);
		adcPdN <= 1'b1;
		dacPdN <= 1'b1;
		adcOn <= 1'b1;
		dacOn <= 1'b1;
		hold(60);
		`CHK("pumpIdle", 1'b0, pumpOn)
		$display("test reset done");

		r = $urandom % 4;
		wr(3'h1, 8'(r));
		wr(3'h0, 8'h03);
		hold(6);
		`CHK("pumpOn", 1'b1, pumpOn)
		hold(CP - 12);
		`CHK("earlyStart", 2'b00, {adcRun, dacRun})
		for (n = 0; n < 200 && dacRun !== 1'b1; n++) @(posedge clock);
		`CHK("dacStart", 1'b1, dacRun)
		k = dacFr;
		for (n = 0; n < 20 && adcRun !== 1'b1; n++) @(posedge clock);
		`CHK("adcSlaveStart", 1'b1, adcRun)
		for (n = 0; n < 2000 && dacOe !== 1'b1; n++) @(posedge clock);
		`CHK("dacInit", 96, near(dacFr - k, 96, 2))
		`CHK("adcHeld", 1'b0, adcValid)
		`CHK("refEarly", 1'b0, refOk)
		$display("test power-up done");

		// Early unmute at a random depth
		k = 200 + $urandom % 600;
		wr(3'h3, 8'h05);
		f = dacFr;
		while (dacFr - f < k) @(posedge clock);
		#1;
		`CHK("midGain", 4096 - 4 * k, near(int'(dacGain), 4096 - 4 * k, 8))
		wr(3'h3, 8'h04);
		ramp(13'h1000, f);
		`CHK("abortBack", k, near(f, k, 2))
		for (sp = 0; sp < 3; sp++) begin
			wr(3'h3, 8'h05 | 8'(sp << 4));
			ramp(13'h0000, f);
			`CHK("muteFrames", 1024 << sp, near(f, 1024 << sp, 2))
			wr(3'h3, 8'h04);
			ramp(13'h1000, f);
			`CHK("unmuteFrames", 1024, near(f, 1024, 2))
		end
		// Speed code 3 must step like quad speed
		wr(3'h3, 8'h35);
		f = dacFr;
		while (dacFr - f < 100) @(posedge clock);
		#1;
		`CHK("speed3Gain", 3996, near(int'(dacGain), 3996, 3))
		wr(3'h3, 8'h04);
		ramp(13'h1000, f);
		`CHK("adcInit", 2640, near(adcDone - adcStart, 2640, 2))
		`CHK("refLate", 1'b1, refOk)
		$display("test soft mute done");

		wr(3'h0, 8'h02);
		hold(8);
		`CHK("adcOff", 2'b00, {adcRun, adcValid})
		rd(3'h1, 8'(r), "adcRegKept");
		rd(3'h4, 8'h67, "status");
		wr(3'h5, 8'hFF);
		rd(3'h6, 8'h00, "unmapped");
		@(posedge clock);
		adcPdN <= 1'b0;
		hold(8);
		wr(3'h1, 8'h03);
		wr(3'h0, 8'h03);
		rd(3'h1, 8'h00, "adcRegPin");
		rd(3'h0, 8'h02, "adcBitPin");
		@(posedge clock);
		masterMode <= 1'b1;
		adcMstOnly <= 1'b1;
		adcPdN <= 1'b1;
		hold(6);
		wr(3'h0, 8'h03);
		for (n = 0; n < 40 && adcRun !== 1'b1; n++) @(posedge clock);
		`CHK("masterStart", 1'b1, adcRun)
		$display("test adc power done");

		wr(3'h3, 8'h01);
		hold(200);
		@(posedge clock);
		dacPdN <= 1'b0;
		hold(8);
		`CHK("dacPinGain", 13'h1000, dacGain)
		`CHK("dacPinOut", 2'b00, {dacRun, dacOe})
		rd(3'h3, 8'h04, "dacRegPin");
		rd(3'h0, 8'h01, "dacBitPin");
		`CHK("pumpAdcOnly", 1'b1, pumpOn)
		@(posedge clock);
		adcPdN <= 1'b0;
		hold(8);
		`CHK("pumpOff", 1'b0, pumpOn)
		@(posedge clock);
		pinMode <= 1'b1;
		dacPdN <= 1'b1;
		hold(10);
		`CHK("pinModePump", 1'b1, pumpOn)
		@(posedge clock);
		dacOn <= 1'b0;
		hold(LOSS + 10);
		`CHK("clockLoss", 1'b0, pumpOn)
		$display("test pin control done");
		results();
	end
endmodule

`default_nettype wire
